// [aux_frame_partner.sv]
module aux_frame_partner
(
	// Clock
	input  wire logic       i_clock,
	// Decoded frame stream
	output logic            o_start,
	output logic            o_stop,
	output logic            o_from_sink,
	output logic            o_byte_vld,
	output logic      [7:0] o_byte
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] fb [0:19];

	//----------------------------------------------------------
	// Frame sender
	//----------------------------------------------------------
	initial
	begin
		o_start     = 1'b0;
		o_stop      = 1'b0;
		o_from_sink = 1'b0;
		o_byte_vld  = 1'b0;
		o_byte      = 8'h00;
	end

	// One frame: start, n bytes, stop; released byte shows inverse
	task automatic send(input logic sink, input int n);
		@(posedge i_clock);
		o_from_sink <= sink;
		o_start     <= 1'b1;
		for (int k = 0; k < n; k++)
		begin
			@(posedge i_clock);
			o_start    <= 1'b0;
			o_byte_vld <= 1'b1;
			o_byte     <= fb[k];
		end
		@(posedge i_clock);
		o_start    <= 1'b0;
		o_byte_vld <= 1'b0;
		o_byte     <= ~o_byte;
		o_stop     <= 1'b1;
		@(posedge i_clock);
		o_stop <= 1'b0;
	endtask : send

	// Request header: command, address, length
	task automatic hdr(input logic [3:0] cmd, input logic [19:0] a, input int n);
		fb[0] = {cmd, a[19:16]};
		fb[1] = a[15:8];
		fb[2] = a[7:0];
		fb[3] = 8'(n - 1);
	endtask : hdr

	// Write request then sink reply, then commit window
	task automatic aux_write(input logic [3:0] cmd, input logic [19:0] a, input int n,
		input logic [31:0] d, input logic nack, input logic [7:0] m);
		hdr(cmd, a, n);
		for (int k = 0; k < n; k++)
		begin
			fb[4 + k] = d[8 * k +: 8];
		end
		send(1'b0, 4 + n);
		if (a > 20'h00fff)
		begin
			nack = 1'b1;
			m    = 8'h00;
		end
		fb[0] = nack ? 8'h10 : 8'h00;
		fb[1] = m;
		send(1'b1, nack ? 2 : 1);
		repeat (24) @(posedge i_clock);
	endtask : aux_write

	// Read request then ack reply carrying nret bytes
	task automatic aux_read(input logic [19:0] a, input int n, input int nret,
		input logic [31:0] d);
		hdr(4'h9, a, n);
		send(1'b0, 4);
		if (a > 20'h00fff)
		begin
			d = '0;
		end
		fb[0] = 8'h00;
		for (int k = 0; k < nret; k++)
		begin
			fb[1 + k] = d[8 * k +: 8];
		end
		send(1'b1, 1 + nret);
		repeat (24) @(posedge i_clock);
	endtask : aux_read

endmodule : aux_frame_partner

// [aux_link_setting_snooper.sv]
module aux_link_setting_snooper
(
	// Clock and reset
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	// Decoded AUX frames, both directions
	input  wire logic        i_aux_start,
	input  wire logic        i_aux_stop,
	input  wire logic        i_aux_from_sink,
	input  wire logic        i_aux_byte_vld,
	input  wire logic [7:0]  i_aux_byte,
	// Shadow register port
	input  wire logic [4:0]  i_reg_index,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	// Output configuration
	output logic      [7:0]  o_link_rate,
	output logic      [4:0]  o_lane_count,
	output logic      [3:0]  o_lane_en,
	output logic             o_enh_frame,
	output logic      [7:0]  o_lane_swing,
	output logic      [7:0]  o_lane_preemph,
	output logic             o_spread_flag,
	output logic             o_power_down,
	output logic             o_test_mode
);

	//--------------------------------------------------------------
	// Decode functions
	//--------------------------------------------------------------
	// Watched address to shadow slot
	function automatic logic [3:0] slot_of_addr(input logic [19:0] a);
		logic [3:0] s;
		s = aux_snoop_pkg::SL_NONE;
		for (int k = 0; k < aux_snoop_pkg::NSLOT; k++)
		begin
			if (a == aux_snoop_pkg::SLOT_ADDR[k])
			begin
				s = 4'(k);
			end
		end
		return s;
	endfunction : slot_of_addr

	// Register index to shadow slot
	function automatic logic [3:0] slot_of_index(input logic [4:0] i);
		logic [3:0] s;
		s = aux_snoop_pkg::SL_NONE;
		for (int k = 0; k < aux_snoop_pkg::NSLOT; k++)
		begin
			if (i == aux_snoop_pkg::SLOT_INDEX[k])
			begin
				s = 4'(k);
			end
		end
		return s;
	endfunction : slot_of_index

	//--------------------------------------------------------------
	// Transaction tracker
	//--------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_WAIT_REP, ST_REP, ST_COMMIT} state_e;

	state_e      st_r, st_nxt;
	logic [3:0]  cmd_r, cmd_nxt;
	logic [19:0] addr_r, addr_nxt;
	logic [7:0]  cnt_r, cnt_nxt;           // Byte index within frame
	logic [4:0]  wcnt_r, wcnt_nxt;         // Write bytes staged
	logic [4:0]  ncm_r, ncm_nxt;           // Bytes to commit
	logic [4:0]  ci_r, ci_nxt;             // Commit issue index
	logic [7:0]  rep_r, rep_nxt;           // Reply command byte
	logic        cm_vld_r;
	logic [4:0]  cm_off_r;
	logic [7:0]  sh_r [0:aux_snoop_pkg::NSLOT-1];
	logic [7:0]  buf_rdata;

	// Frame events
	wire src_start = i_aux_start && !i_aux_from_sink;
	wire snk_start = i_aux_start && i_aux_from_sink;
	wire req_byte  = (st_r == ST_REQ) && i_aux_byte_vld && !i_aux_from_sink;
	wire rep_byte  = (st_r == ST_REP) && i_aux_byte_vld && i_aux_from_sink;
	wire is_write  = (cmd_r == aux_snoop_pkg::CMD_WRITE);
	wire is_read   = (cmd_r == aux_snoop_pkg::CMD_READ);
	wire buf_we    = req_byte && (cnt_r > aux_snoop_pkg::HDR_LAST)
	               && (wcnt_r < 5'(aux_snoop_pkg::BUF_DEPTH));
	wire cm_issue  = (st_r == ST_COMMIT) && (ci_r < ncm_r);
	wire [4:0] m_clip = (i_aux_byte < {3'h0, wcnt_r}) ? i_aux_byte[4:0] : wcnt_r;

	// Next-state logic
	always_comb
	begin
		st_nxt   = st_r;
		cmd_nxt  = cmd_r;
		addr_nxt = addr_r;
		cnt_nxt  = cnt_r;
		wcnt_nxt = wcnt_r;
		ncm_nxt  = ncm_r;
		ci_nxt   = ci_r;
		rep_nxt  = rep_r;
		if (src_start)
		begin
			st_nxt   = ST_REQ;
			cnt_nxt  = 8'h00;
			wcnt_nxt = 5'h00;
		end
		else
		begin
			unique case (st_r)
				ST_IDLE:
				begin
				end
				ST_REQ:
				begin
					if (req_byte)
					begin
						cnt_nxt = cnt_r + 8'h01;
						unique case (cnt_r)
							8'h00:
							begin
								cmd_nxt            = i_aux_byte[7:4];
								addr_nxt[19:16]    = i_aux_byte[3:0];
								if (!i_aux_byte[aux_snoop_pkg::NATIVE_BIT])
								begin
									st_nxt = ST_IDLE;
								end
							end
							8'h01:   addr_nxt[15:8] = i_aux_byte;
							8'h02:   addr_nxt[7:0]  = i_aux_byte;
							default: wcnt_nxt = buf_we ? wcnt_r + 5'h01 : wcnt_r;
						endcase
					end
					if (i_aux_stop)
					begin
						st_nxt = ((cnt_r > aux_snoop_pkg::HDR_LAST) && (is_write || is_read))
						       ? ST_WAIT_REP : ST_IDLE;
					end
				end
				ST_WAIT_REP:
				begin
					if (snk_start)
					begin
						st_nxt  = ST_REP;
						cnt_nxt = 8'h00;
					end
				end
				ST_REP:
				begin
					if (rep_byte)
					begin
						cnt_nxt = cnt_r + 8'h01;
						if (cnt_r == 8'h00)
						begin
							rep_nxt = i_aux_byte;
							if (is_write && i_aux_byte == aux_snoop_pkg::REP_ACK)
							begin
								st_nxt  = ST_COMMIT;
								ncm_nxt = wcnt_r;
								ci_nxt  = 5'h00;
							end
							else if (i_aux_byte != aux_snoop_pkg::REP_ACK
								&& !(is_write && i_aux_byte == aux_snoop_pkg::REP_NACK))
							begin
								st_nxt = ST_IDLE;
							end
						end
						else if (is_write && cnt_r == 8'h01)
						begin
							st_nxt  = ST_COMMIT;
							ncm_nxt = m_clip;
							ci_nxt  = 5'h00;
						end
					end
					if (i_aux_stop && st_nxt == ST_REP)
					begin
						st_nxt = ST_IDLE;
					end
				end
				ST_COMMIT:
				begin
					if (cm_issue)
					begin
						ci_nxt = ci_r + 5'h01;
					end
					else
					begin
						st_nxt = ST_IDLE;
					end
				end
			endcase
		end
	end

	// Tracker state
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			st_r     <= ST_IDLE;
			cmd_r    <= 4'h0;
			addr_r   <= 20'h00000;
			cnt_r    <= 8'h00;
			wcnt_r   <= 5'h00;
			ncm_r    <= 5'h00;
			ci_r     <= 5'h00;
			rep_r    <= 8'h00;
			cm_vld_r <= 1'b0;
			cm_off_r <= 5'h00;
		end
		else
		begin
			st_r     <= st_nxt;
			cmd_r    <= cmd_nxt;
			addr_r   <= addr_nxt;
			cnt_r    <= cnt_nxt;
			wcnt_r   <= wcnt_nxt;
			ncm_r    <= ncm_nxt;
			ci_r     <= ci_nxt;
			rep_r    <= rep_nxt;
			cm_vld_r <= cm_issue;
			cm_off_r <= ci_r;
		end
	end

	// Write payload held until the sink answers
	aux_wbuf u_wbuf
	(
		.i_clock (i_clock),
		.i_we    (buf_we),
		.i_waddr (wcnt_r[3:0]),
		.i_wdata (i_aux_byte),
		.i_raddr (ci_r[3:0]),
		.o_rdata (buf_rdata)
	);

	//--------------------------------------------------------------
	// Shadow write selection
	//--------------------------------------------------------------
	// Read data lands at address plus byte offset
	wire        rd_we    = rep_byte && is_read && (cnt_r != 8'h00)
	                     && (rep_r == aux_snoop_pkg::REP_ACK);
	wire [19:0] rd_addr  = addr_r + {12'h000, cnt_r} - 20'h00001;
	wire [19:0] cm_addr  = addr_r + {15'h0000, cm_off_r};
	wire        aux_we   = rd_we || cm_vld_r;
	wire [7:0]  aux_data = rd_we ? i_aux_byte : buf_rdata;
	wire [3:0]  aux_slot = slot_of_addr(rd_we ? rd_addr : cm_addr);
	wire [3:0]  reg_slot = slot_of_index(i_reg_index);
	wire        reg_we   = i_reg_wr && !aux_we;

	// One shadow per watched address
	generate
		for (genvar k = 0; k < aux_snoop_pkg::NSLOT; k++)
		begin : g_shadow
			wire hit_aux = aux_we && (aux_slot == 4'(k));
			wire hit_reg = reg_we && (reg_slot == 4'(k));
			wire [7:0] wd = (hit_aux ? aux_data : i_reg_wdata) & aux_snoop_pkg::SLOT_MASK[k];
			always_ff @(posedge i_clock)
			begin
				if (i_rst)
				begin
					sh_r[k] <= aux_snoop_pkg::SLOT_RESET[k];
				end
				else if (hit_aux || hit_reg)
				begin
					sh_r[k] <= wd;
				end
			end
		end
	endgenerate

	//--------------------------------------------------------------
	// Effective output configuration
	//--------------------------------------------------------------
	wire       test_on  = sh_r[aux_snoop_pkg::SL_TRESP][1:0] == aux_snoop_pkg::RESP_ACCEPT;
	wire [7:0] eff_rate = test_on ? sh_r[aux_snoop_pkg::SL_TRATE]
	                              : sh_r[aux_snoop_pkg::SL_RATE];
	wire [4:0] eff_lane = test_on ? sh_r[aux_snoop_pkg::SL_TLANES][4:0]
	                              : sh_r[aux_snoop_pkg::SL_LANES][4:0];
	wire [3:0] lane_en  = (eff_lane == aux_snoop_pkg::LANES_ONE) ? 4'h1
	                    : (eff_lane == aux_snoop_pkg::LANES_TWO) ? 4'h3
	                    : 4'hf;
	wire [7:0] eff_sw;
	wire [7:0] eff_pe;

	// Per-lane drive source
	generate
		for (genvar n = 0; n < 4; n++)
		begin : g_lane
			wire [7:0] adj = (n < 2) ? sh_r[aux_snoop_pkg::SL_ADJ_LO]
			                         : sh_r[aux_snoop_pkg::SL_ADJ_HI];
			wire [7:0] trn = sh_r[aux_snoop_pkg::SL_TR0 + n];
			localparam int B = (n % 2) * aux_snoop_pkg::ADJ_LANE;
			assign eff_sw[2*n +: 2] = test_on ? adj[B +: 2]
			                                  : trn[aux_snoop_pkg::SWING_LSB +: 2];
			assign eff_pe[2*n +: 2] = test_on ? adj[B + aux_snoop_pkg::ADJ_PRE +: 2]
			                                  : trn[aux_snoop_pkg::PRE_LSB +: 2];
		end
	endgenerate

	// Registered outputs and readback
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			o_reg_rdata    <= 8'h00;
			o_link_rate    <= aux_snoop_pkg::SLOT_RESET[aux_snoop_pkg::SL_RATE];
			o_lane_count   <= aux_snoop_pkg::LANES_FOUR;
			o_lane_en      <= 4'hf;
			o_enh_frame    <= 1'b0;
			o_lane_swing   <= 8'h00;
			o_lane_preemph <= 8'h00;
			o_spread_flag  <= 1'b0;
			o_power_down   <= 1'b0;
			o_test_mode    <= 1'b0;
		end
		else
		begin
			o_reg_rdata    <= (reg_slot == aux_snoop_pkg::SL_NONE) ? 8'h00 : sh_r[reg_slot];
			o_link_rate    <= eff_rate;
			o_lane_count   <= eff_lane;
			o_lane_en      <= lane_en;
			o_enh_frame    <= sh_r[aux_snoop_pkg::SL_LANES][aux_snoop_pkg::ENH_BIT];
			o_lane_swing   <= eff_sw;
			o_lane_preemph <= eff_pe;
			o_spread_flag  <= sh_r[aux_snoop_pkg::SL_SPREAD][aux_snoop_pkg::SPREAD_BIT];
			o_power_down   <= sh_r[aux_snoop_pkg::SL_POWER][1:0] == aux_snoop_pkg::PWR_D3;
			o_test_mode    <= test_on;
		end
	end

	//--------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_non_native;
		req_byte && cnt_r == 8'h00 && !i_aux_byte[7] && !src_start |=> st_r == ST_IDLE;
	endproperty
	a_non_native: assert property (p_non_native) else $error("tunnelled request parsed");

	property p_test_override;
		test_on |=> o_link_rate == $past(sh_r[aux_snoop_pkg::SL_TRATE]) && o_test_mode;
	endproperty
	a_test_override: assert property (p_test_override) else $error("test rate not used");

	property p_normal_rate;
		!test_on |=> o_link_rate == $past(sh_r[aux_snoop_pkg::SL_RATE]) && !o_test_mode;
	endproperty
	a_normal_rate: assert property (p_normal_rate) else $error("normal rate not used");

	property p_lane0_swing;
		!test_on |=> o_lane_swing[1:0] == $past(sh_r[aux_snoop_pkg::SL_TR0][1:0]);
	endproperty
	a_lane0_swing: assert property (p_lane0_swing) else $error("lane0 swing wrong");

	property p_reserved_zero;
		sh_r[aux_snoop_pkg::SL_LANES][6:5] == 2'b00
		&& (sh_r[aux_snoop_pkg::SL_SPREAD] & 8'hef) == 8'h00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_spread;
		1'b1 |=> o_spread_flag == $past(sh_r[aux_snoop_pkg::SL_SPREAD][4]);
	endproperty
	a_spread: assert property (p_spread) else $error("spread flag wrong");

	property p_read_capture;
		rd_we && rd_addr == 20'h00100 |=> sh_r[aux_snoop_pkg::SL_RATE] == $past(i_aux_byte);
	endproperty
	a_read_capture: assert property (p_read_capture) else $error("read byte lost");

	property p_commit_after_reply;
		$rose(st_r == ST_COMMIT) |-> $past(rep_byte) && $past(is_write);
	endproperty
	a_commit_after_reply: assert property (p_commit_after_reply) else $error("early commit");

	property p_addr_step;
		cm_vld_r ##1 cm_vld_r |-> cm_off_r == $past(cm_off_r) + 5'h01;
	endproperty
	a_addr_step: assert property (p_addr_step) else $error("address not advanced");

	property p_power;
		1'b1 |=> o_power_down == ($past(sh_r[aux_snoop_pkg::SL_POWER][1:0]) == 2'b10);
	endproperty
	a_power: assert property (p_power) else $error("power state wrong");

	c_test_mode:  cover property ($rose(o_test_mode));
	c_commit:     cover property (st_r == ST_COMMIT ##1 cm_vld_r);
	c_nack:       cover property (rep_byte && cnt_r == 8'h00 && i_aux_byte == 8'h10);
	c_read_cap:   cover property (rd_we && aux_slot != aux_snoop_pkg::SL_NONE);

endmodule : aux_link_setting_snooper

// [aux_link_setting_snooper_bench.sv]
module aux_link_setting_snooper_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic       i_clock = 1'b0;
	logic       i_rst   = 1'b1;
	logic       st, sp, fs, bv;
	logic [7:0] bt;
	logic [4:0] i_reg_index = 5'h00;
	logic       i_reg_wr    = 1'b0;
	logic [7:0] i_reg_wdata = 8'h00;
	logic [7:0] o_reg_rdata, o_link_rate, o_lane_swing, o_lane_preemph;
	logic [4:0] o_lane_count;
	logic [3:0] o_lane_en;
	logic       o_enh_frame, o_spread_flag, o_power_down, o_test_mode;
	int         fails  = 0;
	int         checks = 0;
	logic [7:0] rst_exp [0:16] = '{8'h00, 8'h00, 8'h14, 8'h04, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
	logic [7:0] lc [0:3]  = '{8'h01, 8'h02, 8'h04, 8'h03};
	logic [7:0] en [0:3]  = '{8'h01, 8'h03, 8'h0f, 8'h0f};
	logic [7:0] rsp [0:2] = '{8'h00, 8'h02, 8'h03};

	//----------------------------------------------------------
	// Clock, design and partner
	//----------------------------------------------------------
	always #12.5 i_clock = ~i_clock;

	aux_link_setting_snooper u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_aux_start(st),
		.i_aux_stop(sp), .i_aux_from_sink(fs), .i_aux_byte_vld(bv), .i_aux_byte(bt),
		.i_reg_index(i_reg_index), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
		.o_reg_rdata(o_reg_rdata), .o_link_rate(o_link_rate), .o_lane_count(o_lane_count),
		.o_lane_en(o_lane_en), .o_enh_frame(o_enh_frame), .o_lane_swing(o_lane_swing),
		.o_lane_preemph(o_lane_preemph), .o_spread_flag(o_spread_flag),
		.o_power_down(o_power_down), .o_test_mode(o_test_mode));

	aux_frame_partner u_part (.i_clock(i_clock), .o_start(st), .o_stop(sp),
		.o_from_sink(fs), .o_byte_vld(bv), .o_byte(bt));

	//----------------------------------------------------------
	// Compare, register access and reporting
	//----------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [4:0] idx, input logic [7:0] d);
		@(posedge i_clock);
		i_reg_index <= idx;
		i_reg_wr    <= 1'b1;
		i_reg_wdata <= d;
		@(posedge i_clock);
		i_reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
		@(posedge i_clock);
		i_reg_index <= idx;
		repeat (2) @(posedge i_clock);
		#1 chk(o_reg_rdata, exp);
	endtask : rd

	// Output configuration check
	task automatic cfg(input logic [7:0] r, input logic [7:0] c, input logic [7:0] e,
		input logic [7:0] s, input logic [7:0] p, input logic t);
		#1;
		chk(o_link_rate, r);
		chk({3'h0, o_lane_count}, c);
		chk({4'h0, o_lane_en}, e);
		chk(o_lane_swing, s);
		chk(o_lane_preemph, p);
		chk({7'h00, o_test_mode}, {7'h00, t});
	endtask : cfg

	task automatic final_report();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	//----------------------------------------------------------
	// Watchdog
	//----------------------------------------------------------
	initial
	begin
		repeat (6000) @(posedge i_clock);
		fails++;
		final_report();
	end

	//----------------------------------------------------------
	// Tests
	//----------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int i = 0; i < 17; i++)
			rd(5'(i), rst_exp[i]);
		cfg(8'h14, 8'h04, 8'h0f, 8'h00, 8'h00, 1'b0);
		$display("reset values done");
		wr(5'h03, 8'hff);
		rd(5'h03, 8'h9f);
		chk({7'h00, o_enh_frame}, 8'h01);
		wr(5'h08, 8'hff);
		rd(5'h08, 8'h10);
		chk({7'h00, o_spread_flag}, 8'h01);
		wr(5'h07, 8'hff);
		rd(5'h07, 8'h3f);
		wr(5'h01, 8'hff);
		rd(5'h01, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			wr(5'h03, lc[i]);
			rd(5'h03, lc[i]);
			chk({4'h0, o_lane_en}, en[i]);
		end
		wr(5'h07, 8'h00);
		$display("register port done");
		u_part.aux_write(4'h8, 20'h00100, 4, 32'h0900020a, 1'b0, 8'h00);
		cfg(8'h0a, 8'h02, 8'h03, 8'h01, 8'h01, 1'b0);
		chk({7'h00, o_enh_frame}, 8'h00);
		u_part.aux_write(4'h8, 20'h00104, 2, 32'h00001b2d, 1'b1, 8'h01);
		rd(5'h05, 8'h2d);
		rd(5'h06, 8'h00);
		u_part.aux_write(4'h0, 20'h00100, 1, 32'h00000014, 1'b0, 8'h00);
		rd(5'h02, 8'h0a);
		$display("aux writes done");
		// Service vector, then test request reads; short reply keeps lanes 2/3
		u_part.aux_read(20'h00201, 1, 1, 32'h00000002);
		wr(5'h0b, 8'h5a);
		u_part.aux_read(20'h00206, 2, 1, 32'h000000b4);
		rd(5'h0a, 8'hb4);
		rd(5'h0b, 8'h5a);
		u_part.aux_read(20'h00218, 3, 2, 32'h00000601);
		rd(5'h0d, 8'h06);
		rd(5'h0e, 8'h00);
		u_part.aux_read(20'h00220, 1, 1, 32'h00000001);
		rd(5'h0e, 8'h01);
		u_part.aux_write(4'h8, 20'h00260, 1, 32'h00000001, 1'b0, 8'h00);
		cfg(8'h06, 8'h01, 8'h01, 8'h6c, 8'h69, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			u_part.aux_write(4'h8, 20'h00260, 1, {24'h0, rsp[i]}, 1'b0, 8'h00);
			cfg(8'h0a, 8'h02, 8'h03, 8'h05, 8'h05, 1'b0);
		end
		$display("test sequence done");
		u_part.aux_write(4'h8, 20'h00600, 1, 32'h00000002, 1'b0, 8'h00);
		rd(5'h10, 8'h02);
		chk({7'h00, o_power_down}, 8'h01);
		$display("power state done");
		u_part.aux_read(20'h00100, 1, 1, 32'h00000006);
		rd(5'h02, 8'h06);
		chk(o_link_rate, 8'h06);
		$display("rate read capture done");
		final_report();
	end

endmodule : aux_link_setting_snooper_bench

// [aux_snoop_pkg.sv]
package aux_snoop_pkg;

	//--------------------------------------------------------------
	// Frame and command encodings
	//--------------------------------------------------------------
	localparam int         ADDR_W     = 20;
	localparam int         BUF_DEPTH  = 16;
	localparam int         BUF_AW     = 4;
	localparam int         NATIVE_BIT = 7;          // Top bit of the request command nibble
	localparam logic [3:0] CMD_WRITE  = 4'h8;
	localparam logic [3:0] CMD_READ   = 4'h9;
	localparam logic [7:0] REP_ACK    = 8'h00;
	localparam logic [7:0] REP_NACK   = 8'h10;
	localparam logic [7:0] HDR_LAST   = 8'h03;      // Index of the length byte

	//--------------------------------------------------------------
	// Shadow slots
	//--------------------------------------------------------------
	localparam int         NSLOT     = 14;
	localparam int         SL_RATE   = 0;
	localparam int         SL_LANES  = 1;
	localparam int         SL_TR0    = 2;           // Lanes 0..3 at 2..5
	localparam int         SL_SPREAD = 6;
	localparam int         SL_TRESP  = 7;
	localparam int         SL_POWER  = 8;
	localparam int         SL_ADJ_LO = 9;
	localparam int         SL_ADJ_HI = 10;
	localparam int         SL_TREQ   = 11;
	localparam int         SL_TRATE  = 12;
	localparam int         SL_TLANES = 13;
	localparam logic [3:0] SL_NONE   = 4'hf;

	localparam logic [19:0] SLOT_ADDR [0:NSLOT-1] = '{
		20'h00100, 20'h00101, 20'h00103, 20'h00104, 20'h00105, 20'h00106, 20'h00107,
		20'h00260, 20'h00600, 20'h00206, 20'h00207, 20'h00218, 20'h00219, 20'h00220};
	localparam logic [4:0]  SLOT_INDEX [0:NSLOT-1] = '{
		5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h0f, 5'h10, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e};
	localparam logic [7:0]  SLOT_RESET [0:NSLOT-1] = '{
		8'h14, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0]  SLOT_MASK [0:NSLOT-1] = '{
		8'hff, 8'h9f, 8'h3f, 8'h3f, 8'h3f, 8'h3f, 8'h10,
		8'h07, 8'h03, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h1f};

	//--------------------------------------------------------------
	// Field positions and codes
	//--------------------------------------------------------------
	localparam int         ENH_BIT    = 7;
	localparam int         SPREAD_BIT = 4;
	localparam int         SWING_LSB  = 0;
	localparam int         PRE_LSB    = 3;
	localparam int         ADJ_PRE    = 2;          // Pre-emphasis offset in an adjust nibble
	localparam int         ADJ_LANE   = 4;          // Bits per lane in an adjust byte
	localparam logic [1:0] RESP_ACCEPT = 2'b01;
	localparam logic [1:0] PWR_D3      = 2'b10;
	localparam logic [4:0] LANES_ONE   = 5'h01;
	localparam logic [4:0] LANES_TWO   = 5'h02;
	localparam logic [4:0] LANES_FOUR  = 5'h04;

endpackage : aux_snoop_pkg

// [aux_wbuf.sv]
module aux_wbuf
(
	// Clock
	input  wire logic        i_clock,
	// Write port
	input  wire logic        i_we,
	input  wire logic [3:0]  i_waddr,
	input  wire logic [7:0]  i_wdata,
	// Read port, data one cycle later
	input  wire logic [3:0]  i_raddr,
	output logic      [7:0]  o_rdata
);

	//--------------------------------------------------------------
	// Staging store for write payload
	//--------------------------------------------------------------
	logic [7:0] mem_r [0:aux_snoop_pkg::BUF_DEPTH-1];

	// Write and registered read
	always_ff @(posedge i_clock)
	begin
		if (i_we)
		begin
			mem_r[i_waddr] <= i_wdata;
		end
		o_rdata <= mem_r[i_raddr];
	end

endmodule : aux_wbuf
